// File: shared/ngrm_map.vh
// Register offsets, field positions and reset values of the identifier and ROM mapping bank.
`ifndef NGRM_MAP_VH
`define NGRM_MAP_VH
// ==========================================================================
// Register offsets (byte addresses)
`define NGRM_OFF_GUID_UPPER   12'h024
`define NGRM_OFF_GUID_LOWER   12'h028
`define NGRM_OFF_ROM_BASE     12'h034
`define NGRM_OFF_LOAD_CTRL    12'h044
// ==========================================================================
// Fields and reset values
`define NGRM_ROM_BASE_LSB     10
`define NGRM_ROM_OFS_W        10
`define NGRM_GUID_RESET       32'h00000000
`define NGRM_ROM_BASE_RESET   22'h000000
// Load control register: bit 0 commit (write), bit 0 locked (read), bit 1 eeprom present.
`define NGRM_CTRL_COMMIT_BIT  0
`define NGRM_CTRL_EEP_BIT     1
// 1394 address window of the configuration ROM, upper bits compared.
`define NGRM_ROM_WIN_HI       38'h3FFFFC0001
`endif

// File: core/ngrm_regs.v
// Node identifier registers, load lock and configuration ROM address mapping.
//
// Notes on behaviour
// - Hardware reset clears both identifier quadlets to zero.
// - Upper identifier register returns upper 32 bits of the node identifier.
// - With EEPROM present, identifier loads from EEPROM after host bus reset.
// - Without EEPROM, firmware loads identifier after host bus reset; accepted.
// - After load, identifier contents cannot change until the next host bus reset.
// - Lower register holds lower quadlet, same reset, load and lock.
// - Mapping bits 31-10 hold host base, software writable, reset cleared.
// - ROM quadlet reads 0400h-07FFh map to base plus offset low 10 bits.
// - Mapping bits 9-0 ignore writes and read zero.
`timescale 1ns/1ps
`include "ngrm_map.vh"

module ngrm_regs
(
    input  wire        mclk_in,
    input  wire        nrst_in,
    input  wire        host_bus_reset_in,
    input  wire        eeprom_present_in,
    input  wire        eeprom_load_in,
    input  wire [63:0] eeprom_guid_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    input  wire        rom_rd_in,
    input  wire [47:0] rom_ofs_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    output reg         rom_hit_out,
    output reg  [31:0] rom_host_addr_out,
    output reg         guid_locked_out
);

    // ======================================================================
    // State
    reg [31:0] node_guid_upper;
    reg [31:0] node_guid_lower;
    reg [21:0] rom_map_base;
    reg        locked;
    reg        eep_seen;

    wire acc    = psel_in & penable_in & ~pready_out;
    wire wr     = acc & pwrite_in;
    wire sw_ld  = wr & ~locked & ~eep_seen;
    wire commit = wr & (paddr_in == `NGRM_OFF_LOAD_CTRL) & pwdata_in[`NGRM_CTRL_COMMIT_BIT];
    wire mapped = (paddr_in == `NGRM_OFF_GUID_UPPER) | (paddr_in == `NGRM_OFF_GUID_LOWER) |
                  (paddr_in == `NGRM_OFF_ROM_BASE) | (paddr_in == `NGRM_OFF_LOAD_CTRL);

    // ======================================================================
    // Identifier load and lock
    // A host bus reset reopens the load window; the strap is sampled then, so
    // firmware loads are refused whenever an EEPROM will supply the value.
    always @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            node_guid_upper <= `NGRM_GUID_RESET;
            node_guid_lower <= `NGRM_GUID_RESET;
            locked          <= 1'b0;
            eep_seen        <= 1'b0;
        end
        else if (host_bus_reset_in)
        begin
            locked   <= 1'b0;
            eep_seen <= eeprom_present_in;
        end
        else if (!locked)
        begin
            if (eep_seen && eeprom_load_in)
            begin
                node_guid_upper <= eeprom_guid_in[63:32];
                node_guid_lower <= eeprom_guid_in[31:0];
                locked          <= 1'b1;
            end
            else if (sw_ld)
            begin
                if (paddr_in == `NGRM_OFF_GUID_UPPER)
                    node_guid_upper <= pwdata_in;
                if (paddr_in == `NGRM_OFF_GUID_LOWER)
                    node_guid_lower <= pwdata_in;
                if (commit)
                    locked <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Mapping register
    always @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            rom_map_base <= `NGRM_ROM_BASE_RESET;
        else if (wr && paddr_in == `NGRM_OFF_ROM_BASE)
            rom_map_base <= pwdata_in[31:`NGRM_ROM_BASE_LSB];
    end

    // ======================================================================
    // ROM read translation, one cycle after the request
    always @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rom_hit_out       <= 1'b0;
            rom_host_addr_out <= 32'h00000000;
        end
        else
        begin
            rom_hit_out <= rom_rd_in && (rom_ofs_in[47:10] == `NGRM_ROM_WIN_HI);
            rom_host_addr_out <= {rom_map_base, 10'h000} +
                                 {22'h000000, rom_ofs_in[`NGRM_ROM_OFS_W-1:0]};
        end
    end

    // ======================================================================
    // APB slave: one wait state, pready pulses in the second access cycle
    reg [31:0] next_rdata;
    always @*
    begin
        next_rdata = 32'h00000000;
        case (paddr_in)
            `NGRM_OFF_GUID_UPPER: next_rdata = node_guid_upper;
            `NGRM_OFF_GUID_LOWER: next_rdata = node_guid_lower;
            `NGRM_OFF_ROM_BASE:   next_rdata = {rom_map_base, 10'h000};
            `NGRM_OFF_LOAD_CTRL:  next_rdata = {30'h00000000, eep_seen, locked};
            default:              next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            prdata_out      <= 32'h00000000;
            pready_out      <= 1'b0;
            pslverr_out     <= 1'b0;
            guid_locked_out <= 1'b0;
        end
        else
        begin
            pready_out      <= acc;
            pslverr_out     <= acc & ~mapped;
            prdata_out      <= (acc && !pwrite_in) ? next_rdata : 32'h00000000;
            guid_locked_out <= locked;
        end
    end

endmodule

// File: sim/ngrm_eeprom_model.sv
// Serial EEPROM loader model for the identifier bank.
`timescale 1ns/1ps
module ngrm_eeprom_model
(
    input  wire        clk_in,
    input  wire        go_in,
    input  wire [63:0] guid_in,
    output reg         load_out = '0,
    output reg  [63:0] guid_out = '0
);
    // Lines turn to junk after the strobe, so a late sample shows up.
    always @(posedge clk_in)
    begin
        load_out <= go_in;
        guid_out <= go_in ? guid_in : ~guid_out;
    end
endmodule

// File: sim/ngrm_regs_checker.sv
// Port assertions for the identifier bank.
`timescale 1ns/1ps
`include "ngrm_map.vh"
module ngrm_regs_checker
(
    input wire        mclk_in, nrst_in, psel_in, penable_in, pwrite_in, rom_rd_in,
    input wire [11:0] paddr_in,
    input wire [47:0] rom_ofs_in,
    input wire [31:0] prdata_out, rom_host_addr_out,
    input wire        pready_out, pslverr_out, rom_hit_out,
    input wire        host_bus_reset_in, guid_locked_out
);
    // ========
    // Assertions
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    wire take = psel_in && penable_in && !pready_out;
    wire known = paddr_in inside {12'h024, 12'h028, 12'h034, 12'h044};
    wire win = rom_rd_in && rom_ofs_in[47:10] == `NGRM_ROM_WIN_HI;
    answer_due_a: assert property (take |=> pready_out) else $error("late");
    answer_one_a: assert property (pready_out |=> !pready_out) else $error("long");
    err_flag_a: assert property (take |=> pslverr_out == !known) else $error("err");
    idle_zero_a: assert property (!pready_out |-> prdata_out == 32'h0) else $error("data");
    base_low_a: assert property (take && !pwrite_in && paddr_in == 12'h034 |=>
        prdata_out[9:0] == 10'h000) else $error("low bits");
    rom_hit_a: assert property (win |=> rom_hit_out) else $error("no hit");
    rom_miss_a: assert property (!win |=> !rom_hit_out) else $error("hit");
    rom_addr_a: assert property (rom_hit_out |->
        rom_host_addr_out[9:0] == $past(rom_ofs_in[9:0])) else $error("addr");
    lock_hold_a: assert property (guid_locked_out && !host_bus_reset_in &&
        !$past(host_bus_reset_in) |=> guid_locked_out) else $error("lock lost");
endmodule
bind ngrm_regs ngrm_regs_checker i_chk (.*);

// File: sim/tb_ngrm_regs.sv
// Self-checking bench for the identifier bank.
`timescale 1ns/1ps
module tb_ngrm_regs;
    logic mclk_in = '0, nrst_in = '0, host_bus_reset_in = '0, eeprom_present_in = '0;
    logic psel_in = '0, penable_in = '0, pwrite_in = '0, rom_rd_in = '0, go = '0;
    logic [11:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0, rdv, prdata_out, rom_host_addr_out;
    logic [47:0] rom_ofs_in = '0;
    logic [63:0] gval = '0, eeprom_guid_in;
    logic eeprom_load_in, pready_out, pslverr_out, rom_hit_out, guid_locked_out, rde = '0;
    int n_errors = 0, tests_run = 0;
    always #20 mclk_in = ~mclk_in;
    ngrm_regs i_dut (.*);
    ngrm_eeprom_model i_eep (.clk_in(mclk_in), .go_in(go), .guid_in(gval),
        .load_out(eeprom_load_in), .guid_out(eeprom_guid_in));
    // ========
    // Tasks
    task chk(input logic [31:0] s, e);
        tests_run++;
        if (s !== e)
        begin
            $display("ERROR %0t seen %h expected %h", $time, s, e);
            n_errors++;
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'h2, w, a, d};
        @(posedge mclk_in);
        penable_in <= '1;
        do @(posedge mclk_in); while (pready_out !== 1'h1 && ++n < 8);
        n_errors += (n == 8);
        if (n == 8) results();
        rdv = prdata_out;
        rde = pslverr_out;
        {psel_in, penable_in} <= 2'h0;
        @(posedge mclk_in);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        acc('0, a, 32'h0);
        chk(rdv, e);
    endtask
    task rom(input logic [47:0] o, input logic h);
        {rom_rd_in, rom_ofs_in} <= {1'h1, o};
        @(posedge mclk_in);
        {rom_rd_in, rom_ofs_in} <= {1'h0, ~o};
        @(posedge mclk_in);
        chk({31'h0, rom_hit_out}, {31'h0, h});
        if (h) chk(rom_host_addr_out, 32'h12345400 + o[9:0]);
    endtask
    task results;
        $display("tests %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge mclk_in);
        nrst_in <= '1;
        @(posedge mclk_in);
        rd(12'h024, 32'h0);
        rd(12'h028, 32'h0);
        acc('1, 12'h024, 32'h12345678);
        acc('1, 12'h028, 32'h9ABCDEF0);
        acc('1, 12'h044, 32'h1);
        acc('1, 12'h028, 32'h0);
        rd(12'h024, 32'h12345678);
        rd(12'h028, 32'h9ABCDEF0);
        chk({31'h0, rde}, 32'h0);
        chk({31'h0, guid_locked_out}, 32'h1);
        $display("firmware load done");
        acc('1, 12'h034, 32'h123457FF);
        rd(12'h034, 32'h12345400);
        rd(12'h030, 32'h0);
        chk({31'h0, rde}, 32'h1);
        rom(48'hFFFFF0000400, '1);
        rom(48'hFFFFF00007FF, '1);
        rom(48'hFFFFF0000800, '0);
        $display("rom mapping done");
        {host_bus_reset_in, eeprom_present_in} <= 2'h3;
        @(posedge mclk_in);
        {host_bus_reset_in, go, gval} <= {2'h1, 64'hA5A500015A5A0002};
        @(posedge mclk_in);
        go <= '0;
        repeat (2) @(posedge mclk_in);
        rd(12'h024, 32'hA5A50001);
        rd(12'h028, 32'h5A5A0002);
        chk({31'h0, guid_locked_out}, 32'h1);
        acc('1, 12'h024, 32'h0);
        rd(12'h024, 32'hA5A50001);
        $display("eeprom load done");
        results();
    end
endmodule
